// File: core/hbd_headset_detect.sv
`timescale 1ns/10ps
`include "hbd_consts.svh"

module hbd_headset_detect
  import hbd_pkg::*;
#(
  parameter int MS_CYCLES = `HBD_MS_CYCLES
)
(
  input  wire logic                    REF_CLK_IN,       // 100 MHz clock
  input  wire logic                    ARST_N_IN,        // async reset, active low
  input  wire logic [`HBD_ADDR_W-1:0]  REG_ADDR_IN,      // register address
  input  wire logic                    REG_WR_IN,        // write strobe
  input  wire logic                    REG_RD_IN,        // read strobe
  input  wire logic [7:0]              REG_WDATA_IN,     // write data
  input  wire logic                    JACK_SENSE_IN,    // jack inserted, pin
  input  wire logic                    MIC_SENSE_IN,     // mic contact present, pin
  input  wire logic                    BUTTON_SENSE_IN,  // button pressed, pin
  output logic [7:0]                   REG_RDATA_OUT,    // read data
  output logic                         REG_RVALID_OUT,   // read data valid pulse
  output logic [1:0]                   HEADSET_TYPE_OUT, // detected headset type
  output logic                         AC_COUPLED_OUT,   // high-power drivers ac-coupled
  output logic                         FULL_DIFF_OUT,    // stereo fully differential
  output logic                         PSEUDO_DIFF_OUT   // stereo pseudodifferential
);

  // ****************************************
  // helpers
  // ****************************************
  // true on a ms tick whose count is a multiple of 2**shift
  function automatic logic sample_hit(input logic [5:0] ms, input logic [2:0] shift);
    logic [5:0] mask;
    mask = 6'((7'h01 << shift) - 7'h01);
    return (ms & mask) == 6'h00;
  endfunction : sample_hit

  function automatic logic [2:0] count_step(input logic [2:0] cnt);
    return (cnt == 3'h7) ? cnt : 3'(cnt + 3'h1);
  endfunction : count_step

  hbd_cfg_t         cfg_q;
  hbd_sense_t       s1_q, s2_q, s3_q, sense_q;
  hbd_det_state_t   det_q;
  logic [31:0]      div_q;
  logic             ms_tick_q;
  logic [5:0]       ms_q;
  logic [1:0]       jcand_q;
  logic [2:0]       jcnt_q;
  logic             mic_q;
  logic             bcand_q;
  logic [2:0]       bcnt_q;
  logic             btn_q;
  logic             btn_flag_q;
  logic             jack_tick;
  logic             btn_tick;
  logic             btn_rise;
  logic             rd_b;
  logic [1:0]       type_d;

  // ****************************************
  // register writes
  // ****************************************
  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
      cfg_q <= '0;
    else if (REG_WR_IN && REG_ADDR_IN == `HBD_REG_A_ADDR)
    begin
      cfg_q.det_en  <= REG_WDATA_IN[`HBD_A_EN_BIT];
      cfg_q.jack_db <= REG_WDATA_IN[`HBD_A_JDB_MSB:`HBD_A_JDB_LSB];
      cfg_q.btn_db  <= REG_WDATA_IN[`HBD_A_BDB_MSB:0];
    end
    else if (REG_WR_IN && REG_ADDR_IN == `HBD_REG_B_ADDR)
    begin
      cfg_q.ac_coupled  <= REG_WDATA_IN[`HBD_B_COUPLE_BIT];
      cfg_q.full_diff   <= REG_WDATA_IN[`HBD_B_FDIFF_BIT];
      cfg_q.pseudo_diff <= REG_WDATA_IN[`HBD_B_PDIFF_BIT];
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      AC_COUPLED_OUT  <= 1'b0;
      FULL_DIFF_OUT   <= 1'b0;
      PSEUDO_DIFF_OUT <= 1'b0;
      HEADSET_TYPE_OUT <= 2'b00;
    end
    else
    begin
      AC_COUPLED_OUT  <= cfg_q.ac_coupled;
      FULL_DIFF_OUT   <= cfg_q.full_diff;
      PSEUDO_DIFF_OUT <= cfg_q.pseudo_diff;
      HEADSET_TYPE_OUT <= type_d;
    end
  end

  // ****************************************
  // pin synchronisers
  // ****************************************
  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      s1_q    <= '0;
      s2_q    <= '0;
      s3_q    <= '0;
      sense_q <= '0;
    end
    else
    begin
      s1_q <= '{JACK_SENSE_IN, MIC_SENSE_IN, BUTTON_SENSE_IN};
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < 3; i++)
        if (s2_q[i] == s3_q[i])
          sense_q[i] <= s3_q[i];
    end
  end

  // ****************************************
  // millisecond ticks
  // ****************************************
  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      div_q     <= 32'h0;
      ms_tick_q <= 1'b0;
      ms_q      <= 6'h00;
    end
    else
    begin
      ms_tick_q <= (div_q == 32'(MS_CYCLES - 1));
      if (div_q == 32'(MS_CYCLES - 1))
        div_q <= 32'h0;
      else
        div_q <= div_q + 32'h1;
      if (ms_tick_q)
        ms_q <= 6'(ms_q + 6'h01);
    end
  end

  // jack sample period 2 ms << code
  assign jack_tick = ms_tick_q && sample_hit(ms_q, 3'(cfg_q.jack_db + 3'h1));
  // button sample period 1 ms << (code - 1)
  assign btn_tick  = ms_tick_q && sample_hit(ms_q, 3'({1'b0, cfg_q.btn_db} - 3'h1));

  // ****************************************
  // jack debounce and detection state
  // ****************************************
  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      det_q   <= HBD_DET_OFF;
      jcand_q <= 2'b00;
      jcnt_q  <= 3'h0;
      mic_q   <= 1'b0;
    end
    else if (!cfg_q.det_en)
    begin
      det_q   <= HBD_DET_OFF;
      jcand_q <= 2'b00;
      jcnt_q  <= 3'h0;
      mic_q   <= 1'b0;
    end
    else if (jack_tick)
    begin
      if ({sense_q.jack, sense_q.mic} != jcand_q)
      begin
        jcand_q <= {sense_q.jack, sense_q.mic};
        jcnt_q  <= 3'h1;
      end
      else
        jcnt_q <= count_step(jcnt_q);
      case (det_q)
        HBD_DET_OFF:
          det_q <= HBD_DET_ABSENT;
        HBD_DET_ABSENT, HBD_DET_PRESENT:
        begin
          // accept after a full period stable
          // mic latched on acceptance so a chattering candidate never reaches the type
          if ({sense_q.jack, sense_q.mic} == jcand_q && jcnt_q == 3'(`HBD_DB_SAMPLES - 1))
          begin
            det_q <= jcand_q[1] ? HBD_DET_PRESENT : HBD_DET_ABSENT;
            mic_q <= jcand_q[0];
          end
        end
        default:
          det_q <= HBD_DET_OFF;
      endcase
    end
  end

  assign type_d = (det_q != HBD_DET_PRESENT) ? 2'b00 : {mic_q, 1'b1};

  // ****************************************
  // button debounce
  // ****************************************
  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      btn_q   <= 1'b0;
      bcand_q <= 1'b0;
      bcnt_q  <= 3'h0;
    end
    else if (det_q != HBD_DET_PRESENT)
    begin
      btn_q   <= 1'b0;
      bcand_q <= 1'b0;
      bcnt_q  <= 3'h0;
    end
    // code 00 takes the synchronised level directly
    else if (cfg_q.btn_db == 2'b00)
    begin
      btn_q   <= sense_q.button;
      bcand_q <= sense_q.button;
      bcnt_q  <= 3'h0;
    end
    else if (btn_tick)
    begin
      // restart on mismatch, accept after 8 equal samples
      if (sense_q.button != bcand_q)
      begin
        bcand_q <= sense_q.button;
        bcnt_q  <= 3'h1;
      end
      else
      begin
        bcnt_q <= count_step(bcnt_q);
        if (bcnt_q == 3'(`HBD_DB_SAMPLES - 1))
          btn_q <= bcand_q;
      end
    end
  end

  assign btn_rise = (det_q == HBD_DET_PRESENT) && !btn_q && sense_q.button &&
                    ((cfg_q.btn_db == 2'b00) ||
                     (btn_tick && bcand_q && bcnt_q == 3'(`HBD_DB_SAMPLES - 1)));
  assign rd_b = REG_RD_IN && REG_ADDR_IN == `HBD_REG_B_ADDR;

  // ****************************************
  // sticky button flag
  // ****************************************
  // a press landing in the clearing read cycle survives: set beats clear
  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
      btn_flag_q <= 1'b0;
    else if (btn_rise)
      btn_flag_q <= 1'b1;
    else if (rd_b)
      btn_flag_q <= 1'b0;
  end

  // ****************************************
  // register reads
  // ****************************************
  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      REG_RDATA_OUT  <= `HBD_REG_RESET;
      REG_RVALID_OUT <= 1'b0;
    end
    else
    begin
      REG_RVALID_OUT <= REG_RD_IN;
      if (REG_RD_IN && REG_ADDR_IN == `HBD_REG_A_ADDR)
      begin
        REG_RDATA_OUT <= {cfg_q.det_en, type_d, cfg_q.jack_db, cfg_q.btn_db};
      end
      else if (rd_b)
      begin
        REG_RDATA_OUT <= {cfg_q.ac_coupled, cfg_q.full_diff, btn_flag_q,
                          det_q == HBD_DET_PRESENT, cfg_q.pseudo_diff, 3'b000};
      end
      else if (REG_RD_IN)
        REG_RDATA_OUT <= 8'h00;
    end
  end

endmodule : hbd_headset_detect

// File: inc/hbd_consts.svh
// Contract
// - headset detection runs only while the detection enable bit is 1 and is off while it is 0.
// - the two-bit headset type reads 00 none, 01 headset without mic, 11 with mic, 10 unused.
// - jack debounce codes 000 to 101 give 16 to 512 ms sampled at 2 to 64 ms.
// - button debounce code 00 means none and 01 to 11 give 8, 16, 32 ms at 1, 2, 4 ms samples.
// - a detected button press sets a sticky flag that holds until register B is read.
// - reading register B clears the button press flag.
// - a read-only headset flag reads 1 while a headset is detected and 0 otherwise.
// - the coupling bit selects capless drivers at 0 and ac-coupled drivers at 1.
// - configuration bit A at 1 selects the stereo fully differential output arrangement.
// - configuration bit B at 1 selects the stereo pseudodifferential output arrangement.
`ifndef HBD_CONSTS_SVH
`define HBD_CONSTS_SVH

// ****************************************
// register map
// ****************************************
`define HBD_ADDR_W          7
`define HBD_REG_A_ADDR      7'h0d
`define HBD_REG_B_ADDR      7'h0e
`define HBD_REG_RESET       8'h00

// ****************************************
// field positions
// ****************************************
`define HBD_A_EN_BIT        7
`define HBD_A_TYPE_MSB      6
`define HBD_A_JDB_MSB       4
`define HBD_A_JDB_LSB       2
`define HBD_A_BDB_MSB       1
`define HBD_B_COUPLE_BIT    7
`define HBD_B_FDIFF_BIT     6
`define HBD_B_BTN_BIT       5
`define HBD_B_DET_BIT       4
`define HBD_B_PDIFF_BIT     3

// ****************************************
// timing
// ****************************************
`define HBD_CLK_PERIOD_NS   10
`define HBD_MS_NS           1000000
`define HBD_MS_CYCLES       (`HBD_MS_NS / `HBD_CLK_PERIOD_NS)
`define HBD_DB_SAMPLES      8

`endif

// File: inc/hbd_pkg.sv
package hbd_pkg;

  typedef struct packed {
    logic jack;
    logic mic;
    logic button;
  } hbd_sense_t;

  typedef struct packed {
    logic       det_en;
    logic [2:0] jack_db;
    logic [1:0] btn_db;
    logic       ac_coupled;
    logic       full_diff;
    logic       pseudo_diff;
  } hbd_cfg_t;

  typedef enum logic [1:0] {
    HBD_DET_OFF     = 2'b00,
    HBD_DET_ABSENT  = 2'b01,
    HBD_DET_PRESENT = 2'b11
  } hbd_det_state_t;

endpackage : hbd_pkg

// File: verif/hbd_sense_model.sv
`timescale 1ns/10ps
module hbd_sense_model
  import hbd_pkg::*;
(
  input  wire logic       clk_in,    // bench clock
  input  wire hbd_sense_t cmd_in,    // wanted plug state
  input  wire logic       bounce_in, // chatter the jack contact
  output hbd_sense_t      sense_out  // sense pins
);
  logic [2:0] phase_q = 3'h0;
  // period of seven, low for four: passes the pin filter yet never lasts a debounce
  always @(posedge clk_in)
    phase_q <= (phase_q == 3'h6) ? 3'h0 : 3'(phase_q + 3'h1);
  // mic contact only exists through an inserted plug
  always_comb
  begin
    sense_out.jack   = cmd_in.jack & ~(bounce_in && phase_q < 3'h4);
    sense_out.mic    = cmd_in.mic & sense_out.jack;
    sense_out.button = cmd_in.button;
  end
endmodule : hbd_sense_model

// File: verif/hbd_headset_detect_asserts.sv
`timescale 1ns/10ps
`include "hbd_consts.svh"
module hbd_headset_detect_asserts
  import hbd_pkg::*;
#(
  parameter int MS_CYCLES = 4
)
(
  input wire logic       REF_CLK_IN,       // clock
  input wire logic       ARST_N_IN,        // reset
  input wire logic [6:0] REG_ADDR_IN,      // address
  input wire logic       REG_WR_IN,        // write
  input wire logic       REG_RD_IN,        // read
  input wire logic [7:0] REG_WDATA_IN,     // wdata
  input wire logic       JACK_SENSE_IN,    // jack
  input wire logic       MIC_SENSE_IN,     // mic
  input wire logic       BUTTON_SENSE_IN,  // button
  input wire logic [7:0] REG_RDATA_OUT,    // rdata
  input wire logic       REG_RVALID_OUT,   // rvalid
  input wire logic [1:0] HEADSET_TYPE_OUT, // type
  input wire logic       AC_COUPLED_OUT,   // coupling
  input wire logic       FULL_DIFF_OUT,    // full diff
  input wire logic       PSEUDO_DIFF_OUT   // pseudo diff
);
  logic        en_q;
  logic [2:0]  jdb_q;
  logic [15:0] jack_hi_q;
  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
      {en_q, jdb_q} <= 4'h0;
    else if (REG_WR_IN && REG_ADDR_IN == `HBD_REG_A_ADDR)
      {en_q, jdb_q} <= {REG_WDATA_IN[7], REG_WDATA_IN[4:2]};
  end
  // saturates so a long insertion never wraps to a short one
  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
      jack_hi_q <= 16'h0000;
    else if (!JACK_SENSE_IN)
      jack_hi_q <= 16'h0000;
    else if (jack_hi_q != 16'hffff)
      jack_hi_q <= jack_hi_q + 16'h0001;
  end
  // ****
  // sequences and checks
  // ****
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  sequence s_rd_a; REG_RD_IN && REG_ADDR_IN == `HBD_REG_A_ADDR; endsequence
  sequence s_rd_b; REG_RD_IN && REG_ADDR_IN == `HBD_REG_B_ADDR; endsequence
  sequence s_wr_b; REG_WR_IN && REG_ADDR_IN == `HBD_REG_B_ADDR; endsequence
  property p_cfg_follow;
    logic [7:0] d;
    (s_wr_b, d = REG_WDATA_IN) |-> ##2
      {AC_COUPLED_OUT, FULL_DIFF_OUT, PSEUDO_DIFF_OUT} == {d[7], d[6], d[3]};
  endproperty
  a_read_answer: assert property (REG_RD_IN |=> REG_RVALID_OUT)
    else $error("read got no valid pulse");
  a_no_spurious: assert property (!REG_RD_IN |=> !REG_RVALID_OUT)
    else $error("valid pulse without read");
  a_unmapped_zero: assert property (REG_RD_IN && REG_ADDR_IN != `HBD_REG_A_ADDR
    && REG_ADDR_IN != `HBD_REG_B_ADDR |=> REG_RDATA_OUT == 8'h00)
    else $error("unmapped read not zero");
  a_type_legal: assert property (HEADSET_TYPE_OUT != 2'b10)
    else $error("unused type code");
  a_cfg_follow: assert property (p_cfg_follow)
    else $error("driver config not following write");
  a_idle_off: assert property ((!en_q)[*3] |-> HEADSET_TYPE_OUT == 2'b00)
    else $error("type while disabled");
  a_type_readback: assert property (s_rd_a |=> REG_RDATA_OUT[6:5] == HEADSET_TYPE_OUT)
    else $error("type field mismatch");
  a_det_flag: assert property (s_rd_b |=> REG_RDATA_OUT[4] == (HEADSET_TYPE_OUT != 2'b00)
    && REG_RDATA_OUT[2:0] == 3'h0)
    else $error("headset flag mismatch");
  a_debounce_min: assert property ($rose(HEADSET_TYPE_OUT != 2'b00)
    |-> jack_hi_q >= 7 * (2 << jdb_q) * MS_CYCLES)
    else $error("jack accepted too early");
endmodule : hbd_headset_detect_asserts
bind hbd_headset_detect hbd_headset_detect_asserts #(.MS_CYCLES(MS_CYCLES)) u_chk (
  .REF_CLK_IN(REF_CLK_IN), .ARST_N_IN(ARST_N_IN), .REG_ADDR_IN(REG_ADDR_IN),
  .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN), .REG_WDATA_IN(REG_WDATA_IN),
  .JACK_SENSE_IN(JACK_SENSE_IN), .MIC_SENSE_IN(MIC_SENSE_IN),
  .BUTTON_SENSE_IN(BUTTON_SENSE_IN), .REG_RDATA_OUT(REG_RDATA_OUT),
  .REG_RVALID_OUT(REG_RVALID_OUT), .HEADSET_TYPE_OUT(HEADSET_TYPE_OUT),
  .AC_COUPLED_OUT(AC_COUPLED_OUT), .FULL_DIFF_OUT(FULL_DIFF_OUT),
  .PSEUDO_DIFF_OUT(PSEUDO_DIFF_OUT));

// File: verif/tb_headset_button_detect.sv
`timescale 1ns/10ps
`include "hbd_consts.svh"
module tb_headset_button_detect
  import hbd_pkg::*;
;
  localparam int MS = 4;
  localparam logic [6:0] RA = `HBD_REG_A_ADDR;
  localparam logic [6:0] RB = `HBD_REG_B_ADDR;
  logic       clk = 1'b0;
  logic       arst_n = 1'b0;
  logic [6:0] addr = 7'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic       bounce = 1'b0;
  hbd_sense_t cmd = '0;
  hbd_sense_t sense;
  logic [7:0] rdata;
  logic       rvalid;
  logic [1:0] htype;
  logic [2:0] drv;
  int         err_count = 0;
  int         comparisons = 0;
  int         cycles = 0;
  always #5 clk = ~clk;
  hbd_sense_model u_model (.clk_in(clk), .cmd_in(cmd), .bounce_in(bounce), .sense_out(sense));
  hbd_headset_detect #(.MS_CYCLES(MS)) DUT (
    .REF_CLK_IN(clk), .ARST_N_IN(arst_n), .REG_ADDR_IN(addr), .REG_WR_IN(wr),
    .REG_RD_IN(rd), .REG_WDATA_IN(wdata), .JACK_SENSE_IN(sense.jack),
    .MIC_SENSE_IN(sense.mic), .BUTTON_SENSE_IN(sense.button), .REG_RDATA_OUT(rdata),
    .REG_RVALID_OUT(rvalid), .HEADSET_TYPE_OUT(htype), .AC_COUPLED_OUT(drv[2]),
    .FULL_DIFF_OUT(drv[1]), .PSEUDO_DIFF_OUT(drv[0]));
  // ****
  // shared tasks
  // ****
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk);
    {addr, rd} <= {a, 1'b1};
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk({7'h00, rvalid}, 8'h01);
    d = rdata;
  endtask : rd_reg
  task automatic wait_type(input logic [1:0] exp, input int lo, input int hi);
    int n = 0;
    while (htype !== exp && n < 5000)
    begin
      @(posedge clk);
      n++;
    end
    chk({6'h00, htype}, {6'h00, exp});
    chk({7'h00, n >= lo && n <= hi}, 8'h01);
  endtask : wait_type
  task automatic t_regs();
    logic [7:0] d;
    rd_reg(RA, d);
    chk(d, `HBD_REG_RESET);
    rd_reg(RB, d);
    chk(d, `HBD_REG_RESET);
    rd_reg(7'h0f, d);
    chk(d, 8'h00);
    $display("regs done");
  endtask : t_regs
  task automatic t_cfg();
    logic [7:0] d;
    logic [7:0] pat [4] = '{8'hb0, 8'h40, 8'h08, 8'h00};
    for (int i = 0; i < 4; i++)
    begin
      wr_reg(RB, pat[i]);
      repeat (2) @(posedge clk);
      chk({5'h00, drv}, {5'h00, pat[i][7], pat[i][6], pat[i][3]});
      rd_reg(RB, d);
      chk(d, pat[i] & 8'hc8);
    end
    $display("cfg done");
  endtask : t_cfg
  task automatic t_detect();
    int tk;
    logic [7:0] d;
    for (int c = 0; c < 6; c++)
    begin
      tk = (2 << c) * MS;
      wr_reg(RA, {1'b1, 2'b00, 3'(c), 2'b01});
      cmd <= '{jack: 1'b1, mic: c[0], button: 1'b0};
      wait_type(c[0] ? 2'b11 : 2'b01, 7 * tk, 10 * tk + 8);
      rd_reg(RA, d);
      chk(d, {1'b1, c[0], 1'b1, 3'(c), 2'b01});
      cmd <= '0;
      wait_type(2'b00, 7 * tk, 10 * tk + 8);
    end
    $display("detect done");
  endtask : t_detect
  task automatic t_bounce();
    logic bad = 1'b0;
    logic [7:0] d;
    wr_reg(RA, 8'h81);
    cmd <= '{jack: 1'b1, mic: 1'b1, button: 1'b0};
    wait_type(2'b11, 56, 88);
    bounce <= 1'b1;
    repeat (300)
    begin
      @(posedge clk);
      bad |= (htype !== 2'b11);
    end
    bounce <= 1'b0;
    chk({7'h00, bad}, 8'h00);
    rd_reg(RB, d);
    chk(d & 8'h30, 8'h10);
    $display("bounce done");
  endtask : t_bounce
  task automatic t_button();
    int hold;
    logic [7:0] d;
    for (int b = 0; b < 4; b++)
    begin
      wr_reg(RA, {6'h20, 2'(b)});
      hold = 20 + 40 * (1 << b);
      cmd.button <= 1'b1;
      if (b != 0)
      begin
        repeat (10) @(posedge clk);
        rd_reg(RB, d);
        chk(d & 8'h20, 8'h00);
      end
      repeat (hold) @(posedge clk);
      cmd.button <= 1'b0;
      repeat (hold) @(posedge clk);
      rd_reg(RB, d);
      chk(d & 8'h30, 8'h30);
      rd_reg(RB, d);
      chk(d & 8'h20, 8'h00);
    end
    $display("button done");
  endtask : t_button
  task automatic t_disable();
    logic [7:0] d;
    wr_reg(RA, 8'h01);
    repeat (4) @(posedge clk);
    chk({6'h00, htype}, 8'h00);
    cmd.button <= 1'b1;
    repeat (60) @(posedge clk);
    cmd.button <= 1'b0;
    repeat (60) @(posedge clk);
    rd_reg(RB, d);
    chk(d & 8'h30, 8'h00);
    $display("disable done");
  endtask : t_disable
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize
  initial
  begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    t_regs();
    t_cfg();
    t_detect();
    t_bounce();
    t_button();
    t_disable();
    summarize();
  end
  // well above the roughly 10000 cycles the sequence needs
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      err_count++;
      summarize();
    end
  end
endmodule : tb_headset_button_detect
